// ### cal_err_pkg.sv
package cal_err_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] err_off = 8'h08;
  localparam logic [7:0] irq_stat_off = 8'h0c;
  localparam logic [7:0] irq_mask_off = 8'h10;
  localparam logic [7:0] host_err_off = 8'h14;
  // ==========================================
  // field positions
  localparam int ctrl_quad_bit = 0;
  localparam int ctrl_start_bit = 1;
  localparam int stat_busy_bit = 0;
  localparam int stat_done_bit = 1;
  localparam int stat_err_bit = 2;
  localparam int err_stage_lsb = 0;
  localparam int err_code_lsb = 8;
  localparam int err_detail1_lsb = 16;
  localparam int err_detail0_lsb = 24;
  localparam int irq_done_bit = 0;
  localparam int irq_err_bit = 1;
  // ==========================================
  // values
  localparam logic [7:0] buf_err_code = 8'h01;
  localparam logic [7:0] stages_per_rank = 8'h06;
  localparam logic [7:0] dual_last_stage = 8'h0c;
  localparam logic [7:0] quad_last_stage = 8'h18;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [1:0] irq_mask_reset = 2'h0;
  localparam logic [31:0] unmapped_rdata = 32'h0000_0000;
  typedef enum logic [2:0]
  {
    st_rep,
    st_rd_cycle,
    st_rd_center,
    st_wl,
    st_wd_cycle,
    st_wd_center
  } buf_step_t;
endpackage : cal_err_pkg

// ### stage_numberer.sv
`timescale 1ns/1ps
module stage_numberer
(
  input wire logic [1:0] rank, // rank under training
  input wire logic [2:0] step, // step within rank
  output logic [7:0] stage // 1-based stage number
);
  import cal_err_pkg::*;
  // rank-major, six steps per rank
  assign stage = 8'(rank) * stages_per_rank + 8'(step) + 8'h01;
endmodule : stage_numberer

// ### apb_decoder.sv
`timescale 1ns/1ps
module apb_decoder
(
  input wire logic [7:0] paddr, // byte address
  output logic sel_ctrl, // control register hit
  output logic sel_status, // status hit
  output logic sel_err, // error hit
  output logic sel_istat, // irq status hit
  output logic sel_imask, // irq mask hit
  output logic sel_herr, // host error hit
  output logic unmapped // no register
);
  import cal_err_pkg::*;
  assign sel_ctrl = (paddr == ctrl_off);
  assign sel_status = (paddr == status_off);
  assign sel_err = (paddr == err_off);
  assign sel_istat = (paddr == irq_stat_off);
  assign sel_imask = (paddr == irq_mask_off);
  assign sel_herr = (paddr == host_err_off);
  assign unmapped = !(sel_ctrl || sel_status || sel_err || sel_istat || sel_imask || sel_herr);
endmodule : apb_decoder

// ### buf_cal_err.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module buf_cal_err
(
  input wire logic clk, // 50 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic step_valid, // training step result valid
  input wire logic step_edge_found, // edge seen in sweep
  input wire logic step_lat_match, // pattern matched at some latency
  input wire logic step_win_ok, // valid window wide enough
  input wire logic [4:0] step_nibble, // nibble that was trained
  input wire logic host_fail, // host stage failure
  input wire logic [7:0] host_stage, // host stage offset in sequence
  output logic [1:0] cur_rank, // rank being trained
  output logic [2:0] cur_step, // step being trained
  output logic cal_busy, // training in progress
  output logic cal_done, // all stages passed
  output logic cal_error, // a stage failed
  output logic irq // level interrupt
);
  import cal_err_pkg::*;

  // ==========================================
  // register decode
  logic sel_ctrl, sel_status, sel_err, sel_istat, sel_imask, sel_herr, unmapped;
  apb_decoder u_dec
  (
    .paddr(paddr),
    .sel_ctrl(sel_ctrl),
    .sel_status(sel_status),
    .sel_err(sel_err),
    .sel_istat(sel_istat),
    .sel_imask(sel_imask),
    .sel_herr(sel_herr),
    .unmapped(unmapped)
  );
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;

  // ==========================================
  // state
  typedef enum logic [1:0] {s_idle, s_run, s_done, s_fail} cal_state_t;
  cal_state_t state_r;
  logic quad_r;
  logic [7:0] err_stage_r;
  logic [7:0] err_code_r;
  logic [4:0] err_nibble_r;
  logic [7:0] host_err_stage_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;

  wire start = wr && sel_ctrl && pwdata[ctrl_start_bit] && (state_r == s_idle);
  wire running = (state_r == s_run);
  wire [1:0] last_rank = quad_r ? 2'h3 : 2'h1;

  logic [7:0] stage_num;
  stage_numberer u_num
  (
    .rank(cur_rank),
    .step(cur_step),
    .stage(stage_num)
  );

  // ==========================================
  // per-step failure checks
  logic step_fail;
  assign step_fail = (cur_step == 3'(st_rep)) ? !step_edge_found :
                     (cur_step == 3'(st_rd_cycle)) ? !step_lat_match :
                     (cur_step == 3'(st_rd_center)) ? !step_win_ok :
                     (cur_step == 3'(st_wl)) ? !step_edge_found :
                     (cur_step == 3'(st_wd_cycle)) ? !step_lat_match :
                     !step_win_ok;
  wire buf_fail = running && step_valid && step_fail;
  wire hst_fail = running && host_fail;
  wire any_fail = buf_fail || hst_fail;
  wire last_step = (cur_step == 3'(st_wd_center)) && (cur_rank == last_rank);
  wire pass_all = running && step_valid && !step_fail && last_step && !host_fail;
  wire [7:0] host_num = host_stage + (quad_r ? quad_last_stage : dual_last_stage);

  // ==========================================
  // sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= s_idle;
      cur_rank <= 2'h0;
      cur_step <= 3'h0;
    end
    else if (start)
    begin
      state_r <= s_run;
      cur_rank <= 2'h0;
      cur_step <= 3'h0;
    end
    else if (any_fail)
      state_r <= s_fail;
    else if (pass_all)
      state_r <= s_done;
    else if (running && step_valid)
    begin
      if (cur_step == 3'(st_wd_center))
      begin
        cur_step <= 3'h0;
        cur_rank <= cur_rank + 2'h1;
      end
      else
        cur_step <= cur_step + 3'h1;
    end
  end

  // ==========================================
  // error capture, held until reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      err_stage_r <= 8'h00;
      err_code_r <= 8'h00;
      err_nibble_r <= 5'h00;
      host_err_stage_r <= 8'h00;
    end
    else if (buf_fail)
    begin
      err_stage_r <= stage_num;
      err_code_r <= buf_err_code;
      err_nibble_r <= step_nibble;
    end
    else if (hst_fail)
      host_err_stage_r <= host_num;
  end

  // ==========================================
  // control, interrupts
  wire [1:0] ev = {any_fail, pass_all};
  wire clr_istat = rd && sel_istat;
  // clear only the bits the read returned, so a late event survives
  wire [1:0] istat_clr = clr_istat ? prdata[1:0] : 2'h0;
  wire [1:0] istat_nxt = (istat_r & ~istat_clr) | ev;
  wire [1:0] imask_nxt = (wr && sel_imask) ? pwdata[1:0] : imask_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      quad_r <= ctrl_reset[ctrl_quad_bit];
      imask_r <= irq_mask_reset;
      istat_r <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && sel_ctrl && state_r == s_idle)
        quad_r <= pwdata[ctrl_quad_bit];
      imask_r <= imask_nxt;
      istat_r <= istat_nxt;
      irq <= |(istat_nxt & imask_nxt);
    end
  end

  // ==========================================
  // status outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cal_busy <= 1'b0;
      cal_done <= 1'b0;
      cal_error <= 1'b0;
    end
    else
    begin
      cal_busy <= (state_r == s_run && !any_fail && !pass_all) || start;
      cal_done <= (state_r == s_done) || pass_all;
      cal_error <= (state_r == s_fail) || any_fail;
    end
  end

  // ==========================================
  // apb read data, zero-wait answer
  wire [31:0] err_word = {8'h00, 3'h0, err_nibble_r, err_code_r, err_stage_r};
  wire [31:0] stat_word = {29'h0, state_r == s_fail, state_r == s_done, state_r == s_run};
  wire [31:0] ctrl_word = {31'h0, quad_r};
  wire [31:0] rmux = sel_ctrl ? ctrl_word :
                     sel_status ? stat_word :
                     sel_err ? err_word :
                     sel_istat ? {30'h0, istat_r} :
                     sel_imask ? {30'h0, imask_r} :
                     sel_herr ? {24'h0, host_err_stage_r} :
                     unmapped_rdata;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      prdata <= (psel && !penable && !pwrite) ? rmux : 32'h0;
    end
  end

  // ==========================================
  // checks
  property p_code_one;
    @(posedge clk) disable iff (!resetn) buf_fail |=> err_code_r == 8'h01;
  endproperty
  a_code_one: assert property (p_code_one) else $error("error code not 1");
  property p_nibble;
    @(posedge clk) disable iff (!resetn) buf_fail |=> err_nibble_r == $past(step_nibble);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble not captured");
  property p_stage_range;
    @(posedge clk) disable iff (!resetn)
      buf_fail |=> err_stage_r >= 8'h01 && err_stage_r <= (quad_r ? 8'h18 : 8'h0c);
  endproperty
  a_stage_range: assert property (p_stage_range) else $error("stage out of range");
  property p_stage_map;
    @(posedge clk) disable iff (!resetn)
      buf_fail |=> err_stage_r == 8'($past(cur_rank)) * 8'h06 + 8'($past(cur_step)) + 8'h01;
  endproperty
  a_stage_map: assert property (p_stage_map) else $error("stage number wrong");
  property p_rep;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h0 && !step_edge_found |=> state_r == s_fail;
  endproperty
  a_rep: assert property (p_rep) else $error("edge miss not flagged");
  property p_rdc;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h1 && !step_lat_match |=> state_r == s_fail;
  endproperty
  a_rdc: assert property (p_rdc) else $error("read latency miss not flagged");
  property p_wdw;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h5 && !step_win_ok |=> state_r == s_fail;
  endproperty
  a_wdw: assert property (p_wdw) else $error("short window not flagged");
  sequence s_failed;
    state_r == s_fail;
  endsequence
  property p_hold;
    @(posedge clk) disable iff (!resetn)
      s_failed |=> s_failed and $stable(err_stage_r) and $stable(err_nibble_r);
  endproperty
  a_hold: assert property (p_hold) else $error("error fields not held");
  property p_rdw;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h2 && !step_win_ok |=> state_r == s_fail;
  endproperty
  a_rdw: assert property (p_rdw) else $error("short read window not flagged");
  property p_wl;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h3 && !step_edge_found |=> state_r == s_fail;
  endproperty
  a_wl: assert property (p_wl) else $error("rising edge miss not flagged");
  property p_wdc;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && cur_step == 3'h4 && !step_lat_match |=> state_r == s_fail;
  endproperty
  a_wdc: assert property (p_wdc) else $error("write latency miss not flagged");
  property p_host;
    @(posedge clk) disable iff (!resetn)
      hst_fail && !buf_fail |=> host_err_stage_r ==
        8'($past(host_stage) + ($past(quad_r) ? 8'h18 : 8'h0c));
  endproperty
  a_host: assert property (p_host) else $error("host stage number wrong");
  property p_stop;
    @(posedge clk) disable iff (!resetn)
      s_failed |=> cal_error && !cal_busy && $stable(cur_rank) && $stable(cur_step);
  endproperty
  a_stop: assert property (p_stop) else $error("calibration not stopped");
  property p_next_rank;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && !step_fail && !host_fail && cur_step == 3'h5 && !last_step
      |=> cur_rank == $past(cur_rank) + 2'h1 && cur_step == 3'h0;
  endproperty
  a_next_rank: assert property (p_next_rank) else $error("rank order wrong");
  property p_next_step;
    @(posedge clk) disable iff (!resetn)
      running && step_valid && !step_fail && !host_fail && cur_step != 3'h5
      |=> cur_step == $past(cur_step) + 3'h1 && $stable(cur_rank);
  endproperty
  a_next_step: assert property (p_next_step) else $error("step order wrong");
  property p_quad_end;
    @(posedge clk) disable iff (!resetn)
      quad_r && running && step_valid && !step_fail && !host_fail && cur_rank == 2'h3
      && cur_step == 3'h5 |=> state_r == s_done;
  endproperty
  a_quad_end: assert property (p_quad_end) else $error("quad sequence end wrong");
  property p_dual_ranks;
    @(posedge clk) disable iff (!resetn)
      !quad_r && running |-> !cur_rank[1];
  endproperty
  a_dual_ranks: assert property (p_dual_ranks) else $error("dual rank overrun");
  property p_detail;
    @(posedge clk) disable iff (!resetn)
      psel && !penable && !pwrite && sel_err
      |=> prdata[31:24] == 8'h00 && prdata[20:16] == $past(err_nibble_r);
  endproperty
  a_detail: assert property (p_detail) else $error("error detail fields wrong");
  property p_set_wins;
    @(posedge clk) disable iff (!resetn)
      ev != 2'h0 |=> (istat_r & $past(ev)) == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");
  property p_zero_wait;
    @(posedge clk) disable iff (!resetn)
      psel && !penable |=> pready && pslverr == $past(unmapped);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus answer late");
  property p_quad_lock;
    @(posedge clk) disable iff (!resetn)
      state_r != s_idle |=> $stable(quad_r);
  endproperty
  a_quad_lock: assert property (p_quad_lock) else $error("rank mode changed while active");
  property p_done;
    @(posedge clk) disable iff (!resetn)
      pass_all |=> state_r == s_done && cal_done && !cal_busy;
  endproperty
  a_done: assert property (p_done) else $error("pass not reported");
  property p_irq;
    @(posedge clk) disable iff (!resetn) irq == |(istat_r & imask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule : buf_cal_err

// ### dbuf_model.sv
`timescale 1ns/1ps
// ==========================================
// data buffer side: answers each training step
module dbuf_model
(
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic cal_busy, // training running
  input wire logic [1:0] cur_rank, // rank
  input wire logic [2:0] cur_step, // step
  input wire logic [7:0] fail_stage, // stage to fail, 0 none
  input wire logic [4:0] nib, // nibble to report
  input wire logic [1:0] delay, // answer latency
  output logic step_valid, // result strobe
  output logic step_edge_found, // edge seen
  output logic step_lat_match, // latency matched
  output logic step_win_ok, // window wide enough
  output logic [4:0] step_nibble // nibble
);
  logic [1:0] cnt_r;
  logic junk_r;
  wire logic go = cal_busy && !step_valid && cnt_r == delay;
  wire logic [7:0] stage = 8'(cur_rank) * 8'h06 + 8'(cur_step) + 8'h01;
  wire logic pass = stage != fail_stage;
  wire logic sel_e = step_valid && (cur_step == 3'h0 || cur_step == 3'h3);
  wire logic sel_l = step_valid && (cur_step == 3'h1 || cur_step == 3'h4);
  wire logic sel_w = step_valid && (cur_step == 3'h2 || cur_step == 3'h5);
  // idle lines toggle so stale values never pass
  assign step_edge_found = sel_e ? pass : junk_r;
  assign step_lat_match = sel_l ? pass : junk_r;
  assign step_win_ok = sel_w ? pass : junk_r;
  assign step_nibble = step_valid ? nib : {5{junk_r}};
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      cnt_r <= 2'h0;
      junk_r <= 1'b0;
      step_valid <= 1'b0;
    end
    else
    begin
      junk_r <= ~junk_r;
      step_valid <= go;
      cnt_r <= (cal_busy && !step_valid && !go) ? cnt_r + 2'h1 : 2'h0;
    end
endmodule : dbuf_model

// ### test_lrdimm_buffer_cal_error_status.sv
`timescale 1ns/1ps
module test_lrdimm_buffer_cal_error_status;
  import cal_err_pkg::*;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, host_fail;
  logic step_valid, step_edge_found, step_lat_match, step_win_ok;
  logic cal_busy, cal_done, cal_error, irq;
  logic [7:0] paddr, host_stage, fail_stage;
  logic [31:0] pwdata, prdata;
  logic [4:0] step_nibble, nib;
  logic [1:0] cur_rank, delay;
  logic [2:0] cur_step;
  logic [32:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  localparam logic [9:0] cases [0:11] = '{10'h001, 10'h00c, 10'h009, 10'h20d, 10'h218,
    10'h210, 10'h214, 10'h20b, 10'h000, 10'h200, 10'h100, 10'h300};
  buf_cal_err DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .step_valid, .step_edge_found, .step_lat_match, .step_win_ok,
    .step_nibble, .host_fail, .host_stage, .cur_rank, .cur_step, .cal_busy, .cal_done,
    .cal_error, .irq);
  dbuf_model buffers (.clk, .resetn, .cal_busy, .cur_rank, .cur_step, .fail_stage, .nib,
    .delay, .step_valid, .step_edge_found, .step_lat_match, .step_win_ok, .step_nibble);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
    int n;
    if (!w)
      exp_q.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      num_errors++;
      end_of_test();
    end
    @(posedge clk);
  endtask : apb
  task automatic rst(input int n);
    resetn <= 1'b0;
    repeat (n) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : rst
  task automatic irq_is(input logic v);
    @(negedge clk);
    chk({32'h0, irq}, {32'h0, v});
    @(posedge clk);
  endtask : irq_is
  task automatic outs_are(input logic [2:0] v, input logic [5:0] pos);
    @(negedge clk);
    chk({30'h0, cal_busy, cal_done, cal_error}, {30'h0, v});
    if (pos[5])
      chk({28'h0, cur_rank, cur_step}, {28'h0, pos[4:0]});
    @(posedge clk);
  endtask : outs_are
  // read results checked in order of issue
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  initial
  begin
    int n;
    int unsigned s;
    logic quad, hst, e;
    logic [7:0] k;
    logic [5:0] pos;
    {psel, penable, pwrite, host_fail, resetn} = 5'h0;
    {paddr, pwdata, host_stage, fail_stage, nib, delay} = '0;
    s = $urandom(52);
    rst(12);
    apb(1'b0, ctrl_off, 33'h0);
    apb(1'b0, status_off, 33'h0);
    apb(1'b0, irq_mask_off, 33'h0);
    apb(1'b0, 8'h20, {1'b1, unmapped_rdata});
    for (int i = 0; i < 12; i++)
    begin
      {quad, hst, fail_stage} = cases[i];
      nib <= 5'($urandom);
      delay <= 2'($urandom);
      host_stage <= 8'($urandom % 20);
      rst(2);
      apb(1'b1, irq_mask_off, 33'h3);
      apb(1'b1, ctrl_off, {31'h1, quad});
      outs_are(3'h4, 6'h20);
      n = 0;
      while (!(cal_error === 1'b1 || cal_done === 1'b1) && n < 2000)
      begin
        host_fail <= hst && n == 5;
        @(posedge clk);
        n++;
      end
      if (n >= 2000)
      begin
        num_errors++;
        end_of_test();
      end
      e = fail_stage != 8'h0 || hst;
      k = fail_stage - 8'h01;
      pos = (fail_stage != 8'h0) ? {1'b1, 2'(k / stages_per_rank), 3'(k % stages_per_rank)}
        : {!hst, quad, 1'b1, 3'h5};
      outs_are({1'b0, !e, e}, pos);
      apb(1'b0, status_off, e ? 33'h4 : 33'h2);
      irq_is(1'b1);
      apb(1'b0, irq_stat_off, e ? 33'h2 : 33'h1);
      apb(1'b0, irq_stat_off, 33'h0);
      irq_is(1'b0);
      apb(1'b1, ctrl_off, 33'h3);
      apb(1'b0, ctrl_off, {32'h0, quad});
      apb(1'b0, status_off, e ? 33'h4 : 33'h2);
      if (fail_stage != 8'h0)
        apb(1'b0, err_off, {12'h0, nib, buf_err_code, fail_stage});
      if (hst)
        apb(1'b0, host_err_off, {25'h0, host_stage + (quad ? 8'h18 : 8'h0c)});
      $display("case %0d done", i);
    end
    chk(33'(exp_q.size()), 33'h0);
    end_of_test();
  end
endmodule : test_lrdimm_buffer_cal_error_status
